// *** cvam_consts.svh ***
// Register indices, field positions and reset values for the vblank/address block
`ifndef CVAM_CONSTS_SVH
`define CVAM_CONSTS_SVH
`define CVAM_IDX_UNDERLINE 8'h14
`define CVAM_IDX_VBS_LOW 8'h15
`define CVAM_IDX_VB_END 8'h16
`define CVAM_IDX_MODE_CTRL 8'h17
`define CVAM_PORT_INDEX_MONO 16'h03b4
`define CVAM_PORT_DATA_MONO 16'h03b5
`define CVAM_PORT_INDEX_COLOR 16'h03d4
`define CVAM_PORT_DATA_COLOR 16'h03d5
`define CVAM_UL_DWORD 6
`define CVAM_UL_CNT4 5
`define CVAM_MC_RESET 7
`define CVAM_MC_BYTE 6
`define CVAM_MC_WRAP 5
`define CVAM_MC_CNT2 3
`define CVAM_MC_HRSEL 2
`define CVAM_MC_ROWSEL 1
`define CVAM_MC_COMPAT 0
`define CVAM_MSL_VBS_BIT 5
`define CVAM_OVF_VBS_BIT 3
`define CVAM_RST_REG 8'h00
`define CVAM_WRAP_BIT 13
`endif

// *** cvam_pkg.sv ***
// Types for the vblank and address mode block
package cvam_pkg;
	typedef enum logic [1:0] {CVAM_WORD, CVAM_BYTE, CVAM_DWORD} cvam_amode_e;
	typedef logic [15:0] cvam_addr_t;
	typedef logic [11:0] cvam_line_t;
endpackage

// *** cvam_top.sv ***
// Vertical blanking compare, sync gate and display address shaping
`timescale 1ns/10ps
`default_nettype none
`include "cvam_consts.svh"

// What this block does
// - Underline drawn on cell row equal field, text mode only
// - Doubleword bit forces doubleword addressing
// - Mode bits select word, byte, doubleword shift
// - Counter advances every 1, 2 or 4
// - Standard mode: 10-bit blanking start
// - Extended mode: 12-bit blanking start
// - Lines counted from zero at display
// - Blanking ends on low 8-bit match
// - Controller reset bit forces syncs inactive
// - Wrap clear wraps addresses at 16KB
// - Wrap only matters in word mode
// - Retrace select halves vertical counter clock
// - Row-scan select replaces bit 14
// - Compat bit replaces bit 13
// - Registers reached through index/data ports
// - Counter bits reordered per address mode
// - Row-scan substitution after reorganisation
module cvam_top
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	input wire logic char_clk_en,
	input wire logic hretrace_tick,
	input wire logic frame_start,
	input wire logic hsync_raw,
	input wire logic vsync_raw,
	input wire logic [15:0] addr_counter,
	input wire logic [4:0] row_scan,
	input wire logic text_mode,
	input wire logic [7:0] max_scan_line_reg,
	input wire logic [7:0] vertical_overflow_reg,
	input wire logic [7:0] ext_vblank_start_reg,
	input wire logic [7:0] io_ctrl_ext_mode_reg,
	output logic hsync_out,
	output logic vsync_out,
	output logic vblank,
	output logic underline_on,
	output logic addr_advance,
	output logic vline_tick,
	output cvam_pkg::cvam_line_t vline,
	output cvam_pkg::cvam_addr_t decoder_addr_in
);
	import cvam_pkg::*;

	logic [7:0] index_reg;
	logic [7:0] underline_and_address_mode;
	logic [7:0] vblank_start_low;
	logic [7:0] vblank_end;
	logic [7:0] crt_mode_control;
	logic [1:0] char_cnt_reg;
	logic half_reg;
	logic vb_done_reg;
	logic idx_hit, data_hit;
	cvam_amode_e amode;
	cvam_line_t vbs;
	cvam_addr_t reorg_counter_out;
	cvam_addr_t fb_next;
	logic [1:0] step_div;
	logic vtick;

	// Port decode for both mono and colour port pairs
	assign idx_hit = (io_addr == `CVAM_PORT_INDEX_MONO) ||
		(io_addr == `CVAM_PORT_INDEX_COLOR);
	assign data_hit = (io_addr == `CVAM_PORT_DATA_MONO) ||
		(io_addr == `CVAM_PORT_DATA_COLOR);

	// Index latch
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			index_reg <= `CVAM_RST_REG;
		end else if (io_wr && idx_hit) begin
			index_reg <= io_wdata;
		end
	end

	// Indexed register writes
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			underline_and_address_mode <= `CVAM_RST_REG;
			vblank_start_low <= `CVAM_RST_REG;
			vblank_end <= `CVAM_RST_REG;
			crt_mode_control <= `CVAM_RST_REG;
		end else if (io_wr && data_hit) begin
			unique case (index_reg)
				`CVAM_IDX_UNDERLINE: underline_and_address_mode <= io_wdata;
				`CVAM_IDX_VBS_LOW: vblank_start_low <= io_wdata;
				`CVAM_IDX_VB_END: vblank_end <= io_wdata;
				`CVAM_IDX_MODE_CTRL: crt_mode_control <= io_wdata;
				default: ;
			endcase
		end
	end

	// Read data, registered; index port returns the index, unmapped indices and other ports read zero
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			io_rdata <= `CVAM_RST_REG;
		end else if (io_rd && data_hit) begin
			unique case (index_reg)
				`CVAM_IDX_UNDERLINE: io_rdata <= underline_and_address_mode;
				`CVAM_IDX_VBS_LOW: io_rdata <= vblank_start_low;
				`CVAM_IDX_VB_END: io_rdata <= vblank_end;
				`CVAM_IDX_MODE_CTRL: io_rdata <= crt_mode_control;
				default: io_rdata <= `CVAM_RST_REG;
			endcase
		end else if (io_rd && idx_hit) begin
			io_rdata <= index_reg;
		end else begin
			io_rdata <= `CVAM_RST_REG;
		end
	end

	// Sync gate: reset bit low forces both syncs inactive (low)
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			hsync_out <= 1'b0;
			vsync_out <= 1'b0;
		end else begin
			hsync_out <= hsync_raw & crt_mode_control[`CVAM_MC_RESET];
			vsync_out <= vsync_raw & crt_mode_control[`CVAM_MC_RESET];
		end
	end

	// Underline row compare
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			underline_on <= 1'b0;
		end else begin
			underline_on <= text_mode &&
				(row_scan == underline_and_address_mode[4:0]);
		end
	end

	// Character clock divider for the address counter
	always_comb begin
		if (crt_mode_control[`CVAM_MC_CNT2]) begin
			step_div = 2'd1;
		end else if (underline_and_address_mode[`CVAM_UL_CNT4]) begin
			step_div = 2'd3;
		end else begin
			step_div = 2'd0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			char_cnt_reg <= 2'd0;
			addr_advance <= 1'b0;
		end else if (char_clk_en) begin
			addr_advance <= (char_cnt_reg >= step_div);
			char_cnt_reg <= (char_cnt_reg >= step_div) ? 2'd0 :
				char_cnt_reg + 2'd1;
		end else begin
			addr_advance <= 1'b0;
		end
	end

	// Vertical counter clock: direct or halved retrace ticks
	assign vtick = hretrace_tick &&
		(!crt_mode_control[`CVAM_MC_HRSEL] || half_reg);

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			half_reg <= 1'b0;
		end else if (frame_start) begin
			half_reg <= 1'b0;
		end else if (hretrace_tick) begin
			half_reg <= ~half_reg;
		end
	end

	// Line counter, zero at first active line
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			vline <= 12'd0;
			vline_tick <= 1'b0;
		end else begin
			vline_tick <= vtick;
			if (frame_start) begin
				vline <= 12'd0;
			end else if (vtick) begin
				vline <= vline + 12'd1;
			end
		end
	end

	// Blanking start width follows extended-mode bit
	always_comb begin
		if (io_ctrl_ext_mode_reg[0]) begin
			vbs = {ext_vblank_start_reg[3:0], vblank_start_low};
		end else begin
			vbs = {2'b00, max_scan_line_reg[`CVAM_MSL_VBS_BIT],
				vertical_overflow_reg[`CVAM_OVF_VBS_BIT],
				vblank_start_low};
		end
	end

	// Blanking from start-line match until low-byte end match
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			vblank <= 1'b0;
			vb_done_reg <= 1'b0;
		end else if (frame_start) begin
			vblank <= 1'b0;
			vb_done_reg <= 1'b0;
		end else if (!vblank && !vb_done_reg && vline == vbs) begin
			vblank <= 1'b1;
		end else if (vblank && vline[7:0] == vblank_end) begin
			vblank <= 1'b0;
			vb_done_reg <= 1'b1;
		end
	end

	// Address mode selection
	always_comb begin
		if (underline_and_address_mode[`CVAM_UL_DWORD]) begin
			amode = CVAM_DWORD;
		end else if (crt_mode_control[`CVAM_MC_BYTE]) begin
			amode = CVAM_BYTE;
		end else begin
			amode = CVAM_WORD;
		end
	end

	// Reorganise counter bits, then substitute row-scan bits
	always_comb begin
		unique case (amode)
			CVAM_BYTE: reorg_counter_out = addr_counter;
			CVAM_WORD: reorg_counter_out = {addr_counter[14:0],
				crt_mode_control[`CVAM_MC_WRAP] ? addr_counter[15] :
				addr_counter[`CVAM_WRAP_BIT]};
			CVAM_DWORD: reorg_counter_out = {addr_counter[13:0],
				addr_counter[13], addr_counter[12]};
			default: reorg_counter_out = addr_counter;
		endcase
		fb_next = reorg_counter_out;
		if (!crt_mode_control[`CVAM_MC_ROWSEL]) begin
			fb_next[14] = row_scan[1];
		end
		if (!crt_mode_control[`CVAM_MC_COMPAT]) begin
			fb_next[13] = row_scan[0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			decoder_addr_in <= 16'h0000;
		end else begin
			decoder_addr_in <= fb_next;
		end
	end

	// Checks
	a_sync_gate_h: assert property (@(posedge mclk) disable iff (!reset_n)
		!$past(crt_mode_control[`CVAM_MC_RESET]) |-> !hsync_out)
		else $error("hsync active while controller held");
	a_sync_gate_v: assert property (@(posedge mclk) disable iff (!reset_n)
		!$past(crt_mode_control[`CVAM_MC_RESET]) |-> !vsync_out)
		else $error("vsync active while controller held");
	// Skip the edge after reset release: the output still holds its reset value
	a_dword_shift: assert property (@(posedge mclk) disable iff (!reset_n)
		$past(reset_n) &&
		$past(underline_and_address_mode[`CVAM_UL_DWORD]) &&
		$past(crt_mode_control[1:0]) == 2'b11 |->
		decoder_addr_in[15:2] == $past(addr_counter[13:0]))
		else $error("doubleword shift wrong");
	a_byte_pass: assert property (@(posedge mclk) disable iff (!reset_n)
		$past(reset_n) &&
		$past(amode) == CVAM_BYTE && $past(crt_mode_control[1:0]) == 2'b11
		|-> decoder_addr_in == $past(addr_counter))
		else $error("byte mode not identity");
	a_word_wrap: assert property (@(posedge mclk) disable iff (!reset_n)
		$past(reset_n) &&
		$past(amode) == CVAM_WORD && !$past(crt_mode_control[5]) |->
		decoder_addr_in[0] == $past(addr_counter[13]))
		else $error("word wrap bit wrong");
	a_row_sub14: assert property (@(posedge mclk) disable iff (!reset_n)
		$past(reset_n) &&
		!$past(crt_mode_control[1]) |->
		decoder_addr_in[14] == $past(row_scan[1]))
		else $error("row scan bit 1 not substituted");
	a_row_sub13: assert property (@(posedge mclk) disable iff (!reset_n)
		$past(reset_n) &&
		!$past(crt_mode_control[0]) |->
		decoder_addr_in[13] == $past(row_scan[0]))
		else $error("row scan bit 0 not substituted");
	a_underline_row: assert property (@(posedge mclk) disable iff (!reset_n)
		$past(reset_n) &&
		$past(text_mode) && $past(row_scan) ==
		$past(underline_and_address_mode[4:0]) |-> underline_on)
		else $error("underline missing");
	a_vblank_end: assert property (@(posedge mclk) disable iff (!reset_n)
		vblank && !frame_start && vline[7:0] == vblank_end |=> !vblank)
		else $error("blanking did not end");
	a_count_one: assert property (@(posedge mclk) disable iff (!reset_n)
		char_clk_en && step_div == 2'd0 |=> addr_advance)
		else $error("advance missed");
endmodule // cvam_top
`default_nettype wire

// *** cvam_host_model.sv ***
// Host side model that drives the indexed register port
`timescale 1ns/10ps
`default_nettype none
module cvam_host_model (
	input wire logic mclk,
	output var logic [15:0] io_addr,
	output var logic io_wr,
	output var logic io_rd,
	output var logic [7:0] io_wdata
);
	initial begin
		io_addr = 16'h0000;
		{io_wr, io_rd} = 2'b00;
		io_wdata = 8'h00;
	end
	// One strobed cycle; the released bus shows inverted values
	task automatic cyc(input logic [15:0] a, input logic [7:0] d,
		input logic w);
		@(negedge mclk);
		io_addr = a;
		io_wdata = d;
		io_wr = w;
		io_rd = !w;
		@(negedge mclk);
		{io_wr, io_rd} = 2'b00;
		io_addr = ~a;
		io_wdata = ~d;
	endtask
	// Index write on the index port, then a data write
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		cyc(16'h03d4, i, 1'b1);
		cyc(16'h03d5, d, 1'b1);
	endtask
	// Index write on the index port, then a data read
	task automatic rd(input logic [7:0] i);
		cyc(16'h03b4, i, 1'b1);
		cyc(16'h03b5, 8'h00, 1'b0);
	endtask
endmodule // cvam_host_model
`default_nettype wire

// *** crtc_vblank_and_address_mode_bench.sv ***
// Self-checking bench for the vblank and address mode block
`timescale 1ns/10ps
`default_nettype none
module crtc_vblank_and_address_mode_bench;
	import cvam_pkg::*;
	typedef struct {int s; logic [15:0] e;} cvam_note_s;
	logic mclk, reset_n, io_wr, io_rd, char_clk_en, hretrace_tick;
	logic frame_start, hsync_raw, vsync_raw, text_mode, hsync_out;
	logic vsync_out, vblank, underline_on, addr_advance, vline_tick;
	logic [15:0] io_addr, addr_counter;
	logic [7:0] io_wdata, io_rdata, msl, ovf, xs, xm, ul, mc;
	logic [4:0] row_scan;
	cvam_line_t vline;
	cvam_addr_t decoder_addr_in;
	cvam_note_s q[$];
	string nm[8] = '{"rdata", "syncs", "addr", "vblank", "vline", "uline",
		"adv", "vticks"};
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	int advs = 0;
	int vts = 0;
	cvam_top u_cvam_top (.mclk, .reset_n, .io_addr, .io_wr, .io_rd,
		.io_wdata, .io_rdata, .char_clk_en, .hretrace_tick, .frame_start,
		.hsync_raw, .vsync_raw, .addr_counter, .row_scan, .text_mode,
		.max_scan_line_reg(msl), .vertical_overflow_reg(ovf),
		.ext_vblank_start_reg(xs), .io_ctrl_ext_mode_reg(xm), .hsync_out,
		.vsync_out, .vblank, .underline_on, .addr_advance, .vline_tick,
		.vline, .decoder_addr_in);
	cvam_host_model u_cvam_host_model (.mclk, .io_addr, .io_wr, .io_rd,
		.io_wdata);
	// Clock source
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic stop_test;
		if (n_errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic note(input int s, input logic [15:0] e);
		q.push_back('{s, e});
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			hretrace_tick = 1'b1;
			step(1);
			hretrace_tick = 1'b0;
			step(1);
		end
	endtask
	task automatic fstart;
		frame_start = 1'b1;
		step(1);
		frame_start = 1'b0;
	endtask
	// Shaped address from counter, row scan and mode bits
	function automatic cvam_addr_t exp_addr(input logic [15:0] c,
		input logic [4:0] r);
		cvam_addr_t x;
		if (ul[6]) x = {c[13:0], c[13], c[12]};
		else if (mc[6]) x = c;
		else x = {c[14:0], mc[5] ? c[15] : c[13]};
		if (!mc[1]) x[14] = r[1];
		if (!mc[0]) x[13] = r[0];
		return x;
	endfunction
	function automatic logic [15:0] pick(input int s);
		case (s)
			0: return {8'h00, io_rdata};
			1: return {14'h0000, hsync_out, vsync_out};
			2: return decoder_addr_in;
			3: return {15'h0000, vblank};
			4: return {4'h0, vline};
			5: return {15'h0000, underline_on};
			6: return advs[15:0];
			default: return vts[15:0];
		endcase
	endfunction
	// Blanking over one frame; start line works out to 261
	task automatic vframe(input logic [7:0] o, input logic [7:0] m,
		input logic [7:0] e);
		{ovf, xm, xs} = {o, m, e};
		fstart();
		ticks(5);
		step(2);
		note(3, 0);
		note(4, 5);
		ticks(256);
		step(2);
		note(3, 1);
		ticks(4);
		step(2);
		note(3, 1);
		ticks(1);
		step(2);
		note(3, 0);
	endtask
	// Watcher: compares every queued note, oldest first, with the settled outputs
	always begin
		cvam_note_s n;
		@(negedge mclk);
		#1;
		while (q.size() > 0) begin
			n = q.pop_front();
			check_count++;
			if (pick(n.s) !== n.e) begin
				n_errors++;
				$display("Error %s expected %h seen %h", nm[n.s], n.e, pick(n.s));
			end
		end
	end
	// Advance pulse counter and hang guard
	always @(posedge mclk) begin
		if (addr_advance === 1'b1) advs++;
		if (vline_tick === 1'b1) vts++;
		cyc++;
		if (cyc == 8000) begin
			n_errors++;
			stop_test();
		end
	end
	initial begin
		{reset_n, char_clk_en, hretrace_tick, frame_start} = 4'h0;
		{hsync_raw, vsync_raw, text_mode} = 3'b000;
		{addr_counter, row_scan} = 21'h000000;
		{msl, ovf, xs, xm} = 32'h00000000;
		ul = 8'($urandom(32'hfeb9a84c));
		step(10);
		reset_n = 1'b1;
		for (int i = 0; i < 4; i++) begin
			ul = 8'($urandom);
			u_cvam_host_model.wr(8'h14 + 8'(i), ul);
			u_cvam_host_model.rd(8'h14 + 8'(i));
			note(0, {8'h00, ul});
		end
		u_cvam_host_model.rd(8'h18);
		note(0, 0);
		{hsync_raw, vsync_raw} = 2'b11;
		u_cvam_host_model.wr(8'h17, 8'h00);
		step(2);
		note(1, 0);
		u_cvam_host_model.wr(8'h17, 8'h80);
		step(2);
		note(1, 3);
		for (int i = 0; i < 24; i++) begin
			ul = 8'($urandom);
			mc = 8'($urandom);
			ul[6] = i[2];
			mc[7:5] = {1'b1, i[4:3]};
			u_cvam_host_model.wr(8'h14, ul);
			u_cvam_host_model.wr(8'h17, mc);
			addr_counter = 16'($urandom);
			row_scan = i[0] ? ul[4:0] : 5'($urandom);
			text_mode = i[1];
			step(2);
			note(2, exp_addr(addr_counter, row_scan));
			note(5, {15'h0000, text_mode && row_scan == ul[4:0]});
		end
		for (int m = 0; m < 4; m++) begin
			u_cvam_host_model.wr(8'h14, {2'b00, m[0], 5'h00});
			u_cvam_host_model.wr(8'h17, {4'h8, m[1], 3'b000});
			step(2);
			advs = 0;
			repeat (12) begin
				char_clk_en = 1'b1;
				step(1);
				char_clk_en = 1'b0;
				step(1);
			end
			step(2);
			note(6, m == 0 ? 12 : m == 1 ? 3 : 6);
		end
		u_cvam_host_model.wr(8'h15, 8'h05);
		u_cvam_host_model.wr(8'h16, 8'h0a);
		u_cvam_host_model.wr(8'h17, 8'h80);
		vframe(8'h08, 8'h00, 8'h00);
		vframe(8'h00, 8'h01, 8'h01);
		u_cvam_host_model.wr(8'h17, 8'h84);
		fstart();
		vts = 0;
		ticks(10);
		step(2);
		note(4, 5);
		note(7, 5);
		// Mid-run reset: registers back to zero, syncs gated, word mode
		reset_n = 1'b0;
		step(2);
		note(1, 0);
		note(4, 0);
		reset_n = 1'b1;
		{ul, mc} = 16'h0000;
		step(2);
		note(2, exp_addr(addr_counter, row_scan));
		note(1, 0);
		u_cvam_host_model.rd(8'h17);
		note(0, 0);
		step(2);
		stop_test();
	end
endmodule // crtc_vblank_and_address_mode_bench
`default_nettype wire
